// File: pkg/qpc_pkg.sv
// shared constants and types for the quadrature position counter
package qpc_pkg;

   // ==========================================================
   // bus geometry
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned STRB_W = DATA_W / 8;

   // ==========================================================
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_LIMIT = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_INIT = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h18;

   // ==========================================================
   // decoder_control fields
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_MODE_LSB = 1;
   localparam int unsigned CTRL_MODE_MSB = 2;
   localparam int unsigned CTRL_INIT_BIT = 3;

   // counter_reset_mode_field encodings
   typedef enum logic [1:0]
   {
      QPC_MODE_INDEX = 2'b00,
      QPC_MODE_LIMIT = 2'b01,
      QPC_MODE_FIRST = 2'b10,
      QPC_MODE_FREE = 2'b11
   } qpc_mode_t;

   // ==========================================================
   // decoder_status fields
   localparam int unsigned ST_FIRST_SEEN = 0;
   localparam int unsigned ST_FIRST_DIR = 1;
   localparam int unsigned ST_DIR = 2;
   localparam int unsigned ST_PENDING = 3;
   localparam int unsigned ST_REF_LSB = 4;
   localparam int unsigned ST_REF_MSB = 5;

   // ==========================================================
   // interrupt status / mask bits
   localparam int unsigned INT_W = 5;
   localparam int unsigned INT_INDEX = 0;
   localparam int unsigned INT_FIRST = 1;
   localparam int unsigned INT_DIRCHG = 2;
   localparam int unsigned INT_PHASE = 3;
   localparam int unsigned INT_WRAP = 4;

   // ==========================================================
   // reset values and responses
   localparam logic [DATA_W-1:0] LIMIT_RST = 32'hffff_ffff;
   localparam logic [DATA_W-1:0] INIT_RST = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // quadrature states
   localparam logic [1:0] AB_00 = 2'b00;
   localparam logic [1:0] AB_01 = 2'b01;
   localparam logic [1:0] AB_11 = 2'b11;
   localparam logic [1:0] AB_10 = 2'b10;

endpackage

// File: tb/qpc_enc_model.sv
// behavioural incremental encoder for the position counter bench
`timescale 1ns/1ns
module qpc_enc_model
#(
   // input qualification select; 2'b11 is asynchronous and never allowed
   parameter logic [1:0] QUAL_SEL = 2'b00
)
(
   // clock
   input wire logic clk_i,
   // encoder lines
   output logic phase_a_o,
   output logic phase_b_o,
   output logic index_o
);
   logic [1:0] pos;
   initial
   begin
      pos = 2'd0;
      phase_a_o = 1'b0;
      phase_b_o = 1'b0;
      index_o = 1'b0;
   end
   // lines move only just after a rising edge: an unsynchronised edge
   // could be missed by the counter
   task automatic step(input logic fwd);
      logic [1:0] np;
      np = fwd ? pos + 2'd1 : pos - 2'd1;
      @(posedge clk_i);
      pos <= np;
      phase_a_o <= np[1];
      phase_b_o <= np[1] ^ np[0];
      repeat (3) @(posedge clk_i);
   endtask
   task automatic idx(input logic lvl);
      @(posedge clk_i);
      index_o <= lvl;
      repeat (3) @(posedge clk_i);
   endtask
endmodule

// File: tb/qpc_top_sva.sv
// port assertions for the quadrature position counter
`timescale 1ns/1ns
module qpc_chk
#(
   parameter int unsigned CW = 32
)
(
   // clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [qpc_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   // encoder and status
   input wire logic phase_a_i,
   input wire logic phase_b_i,
   input wire logic index_i,
   input wire logic [CW-1:0] position_count_o,
   input wire logic forward_o,
   input wire logic irq_o
);
   import qpc_pkg::*;
   logic [1:0] ab;
   logic quiet;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   assign ab = {phase_a_i, phase_b_i};
   // writes and index pulses may legally move the count, so leave them out
   assign quiet = !index_i && !s_axi_wvalid && !s_axi_awvalid;
   // ==========================================================
   // bus handshakes
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read response late");
   a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready &&
      !s_axi_wready) else $error("write taken while response pending");
   a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp ==
      RESP_SLVERR |-> s_axi_rdata == 32'h0) else $error("unmapped data");
   a_irq_clear: assert property ($fell(irq_o) |-> $rose(s_axi_bvalid))
      else $error("interrupt dropped without a write");
   // ==========================================================
   // encoder side
   a_count_quiet: assert property (
      ($stable(ab) && quiet) [*3] |=> $stable(position_count_o))
      else $error("count moved without a step");
   a_dir_source: assert property (
      $changed(forward_o) |-> $past(ab) != $past(ab, 2) ||
      $past(ab, 2) != $past(ab, 3) || $past(ab, 3) != $past(ab, 4))
      else $error("direction moved without a step");
   c_irq_raise: cover property ($rose(irq_o));
   c_read_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
   c_count_zero: cover property ($changed(position_count_o) &&
      ~|position_count_o);
endmodule
bind qpc_top qpc_chk #(.CW(CW)) i_chk
(
   .clk_i(clk_i), .rst_i(rst_i), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .phase_a_i(phase_a_i),
   .phase_b_i(phase_b_i), .index_i(index_i),
   .position_count_o(position_count_o), .forward_o(forward_o),
   .irq_o(irq_o)
);

// File: tb/tb_top.sv
// self-checking bench for the quadrature position counter
`timescale 1ns/1ns
module tb_top;
   import qpc_pkg::*;
   // ==========================================================
   // signals
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [3:0] ws = 4'hf;
   logic [2:0] prot = 3'h0;
   logic awr, wrdy, bv, arr, rv, pa, pb, ix, fwd, irq;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, count;
   int error_cnt = 0, check_count = 0, cyc = 0;
   always #2 clk_i = ~clk_i;
   qpc_enc_model i_enc
      (.clk_i(clk_i), .phase_a_o(pa), .phase_b_o(pb), .index_o(ix));
   qpc_top i_dut
   (
      .clk_i(clk_i), .rst_i(rst_i), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(prot),
      .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_araddr(ara), .s_axi_arprot(prot), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .phase_a_i(pa), .phase_b_i(pb), .index_i(ix),
      .position_count_o(count), .forward_o(fwd), .irq_o(irq)
   );
   // ==========================================================
   // shared tasks
   task automatic give_verdict();
      if (error_cnt == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // address and data are offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {awa, wd, awv, wv, br} <= {a, d, 3'b111};
      do
      begin
         @(posedge clk_i);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end
      while (!bv);
      resp = bresp;
      br <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      {ara, arv, rr} <= {a, 2'b11};
      do
      begin
         @(posedge clk_i);
         if (arr) arv <= 1'b0;
      end
      while (!rv);
      resp = rresp;
      rr <= 1'b0;
      chk(rdata, exp);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs();
      prot <= 3'h5;
      rd(OFF_CTRL, 32'h0);
      rd(OFF_LIMIT, LIMIT_RST);
      rd(OFF_INIT, INIT_RST);
      rd(OFF_INT_MASK, 32'h0);
      rd(8'h40, 32'h0);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      wr(8'h44, 32'h1);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      wr(OFF_LIMIT, 32'h64);
      rd(OFF_LIMIT, 32'h64);
      // only byte lane 1 may land
      ws <= 4'h2;
      wr(OFF_LIMIT, 32'h1234_5678);
      ws <= 4'hf;
      rd(OFF_LIMIT, 32'h5664);
      wr(OFF_LIMIT, 32'h64);
   endtask
   task automatic t_count();
      wr(OFF_CTRL, 32'h7);
      repeat (3) i_enc.step(1'b1);
      chk(count, 32'h3);
      chk({31'h0, fwd}, 32'h1);
      repeat (2) i_enc.step(1'b0);
      rd(OFF_COUNT, 32'h1);
      chk({31'h0, fwd}, 32'h0);
   endtask
   // limit mode wraps both ways between zero and the limit
   task automatic t_wrap();
      wr(OFF_CTRL, 32'h3);
      repeat (2) i_enc.step(1'b0);
      chk(count, 32'h64);
      i_enc.step(1'b1);
      chk(count, 32'h0);
      i_enc.step(1'b1);
      rd(OFF_INT_STAT, 32'h14);
   endtask
   // first index at quadrature state 11 moving forward
   task automatic t_index();
      wr(OFF_CTRL, 32'h1);
      i_enc.step(1'b1);
      i_enc.idx(1'b1);
      chk(count, 32'h0);
      rd(OFF_STATUS, 32'h37);
      chk({31'h0, irq}, 32'h0);
      wr(OFF_INT_MASK, 32'h2);
      chk({31'h0, irq}, 32'h1);
      wr(OFF_INT_STAT, 32'h1f);
      chk({31'h0, irq}, 32'h0);
      i_enc.idx(1'b0);
      repeat (5) i_enc.step(1'b1);
      i_enc.idx(1'b1);
      repeat (2) i_enc.step(1'b1);
      chk(count, 32'h7);
      i_enc.step(1'b1);
      chk(count, 32'h0);
      i_enc.idx(1'b0);
      repeat (6) i_enc.step(1'b1);
      i_enc.step(1'b0);
      i_enc.idx(1'b1);
      i_enc.step(1'b0);
      chk(count, 32'h64);
      i_enc.idx(1'b0);
   endtask
   // the faulty reset value is left open; only the recovery is judged
   task automatic t_defect();
      repeat (2) i_enc.step(1'b0);
      i_enc.idx(1'b1);
      repeat (2) i_enc.step(1'b1);
      i_enc.idx(1'b0);
      repeat (2) i_enc.step(1'b1);
      i_enc.idx(1'b1);
      repeat (2) i_enc.step(1'b1);
      chk(count, 32'h0);
      i_enc.idx(1'b0);
   endtask
   task automatic t_init();
      wr(OFF_INIT, 32'h55);
      wr(OFF_CTRL, 32'hf);
      i_enc.step(1'b1);
      i_enc.idx(1'b1);
      chk(count, 32'h55);
      i_enc.step(1'b0);
      chk(count, 32'h54);
      i_enc.idx(1'b0);
      i_enc.idx(1'b1);
      chk(count, 32'h55);
      i_enc.idx(1'b0);
      wr(OFF_STATUS, 32'h1);
      rd(OFF_STATUS, 32'h30);
   endtask
   // ==========================================================
   // run control
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_count();
      t_wrap();
      t_index();
      t_defect();
      t_init();
      give_verdict();
   end
endmodule

// File: verilog/qpc_quad_decoder.sv
// quadrature edge, direction and index edge decoder
`timescale 1ns/1ns
module qpc_quad_decoder
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // encoder inputs, already synchronous to clk_i
   input wire logic phase_a_i,
   input wire logic phase_b_i,
   input wire logic index_i,
   // decoded events
   output logic step_o,
   output logic forward_o,
   output logic [1:0] ab_o,
   output logic phase_err_o,
   output logic dir_change_o,
   output logic index_rise_o
);
   import qpc_pkg::*;

   // =============================================================
   // state
   typedef struct packed {
      logic primed;
      logic [1:0] ab;
      logic idx;
      logic step;
      logic fwd;
      logic perr;
      logic dchg;
      logic irise;
   } qpc_dec_t;

   qpc_dec_t r;
   qpc_dec_t next_r;
   logic [1:0] cur;

   // forward gray sequence 00 -> 01 -> 11 -> 10 -> 00
   function automatic logic [1:0] fwd_next(input logic [1:0] s);
      case (s)
         AB_00: fwd_next = AB_01;
         AB_01: fwd_next = AB_11;
         AB_11: fwd_next = AB_10;
         default: fwd_next = AB_00;
      endcase
   endfunction

   // =============================================================
   // decode
   always_comb
   begin
      cur = {phase_a_i, phase_b_i};
      next_r = r;
      next_r.step = 1'b0;
      next_r.perr = 1'b0;
      next_r.dchg = 1'b0;
      next_r.primed = 1'b1;
      next_r.ab = cur;
      next_r.idx = index_i;
      next_r.irise = r.primed && index_i && !r.idx;
      // first sample after reset only loads the phase history
      if (r.primed && cur != r.ab)
      begin
         if (cur == fwd_next(r.ab))
         begin
            next_r.step = 1'b1;
            next_r.fwd = 1'b1;
            next_r.dchg = !r.fwd;
         end
         else if (r.ab == fwd_next(cur))
         begin
            next_r.step = 1'b1;
            next_r.fwd = 1'b0;
            next_r.dchg = r.fwd;
         end
         else
         begin
            // both phases moved at once: no count, flag it
            next_r.perr = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         r <= '0;
         r.fwd <= 1'b1;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign step_o = r.step;
   assign forward_o = r.fwd;
   assign ab_o = r.ab;
   assign phase_err_o = r.perr;
   assign dir_change_o = r.dchg;
   assign index_rise_o = r.irise;

endmodule

// File: verilog/qpc_top.sv
// quadrature position counter with index reset, axi4-lite registers
// Functional notes
// - reset mode field 00 selects position reset on every index event
// - index reset while moving forward clears count to zero next clock
// - index reset while moving reverse loads the limit next clock
// - first index sets a seen flag and records the direction then
// - edge at first index is stored; later resets use that same edge
// - reversal during index keeps waiting for stored edge; may offset
// - next index without reversal resets correctly and recovers
// - index initialization mode ignores direction changes during index
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
module qpc_top
#(
   parameter int unsigned CW = 32
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // axi4-lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [qpc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // axi4-lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [qpc_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [qpc_pkg::STRB_W-1:0] s_axi_wstrb,
   // axi4-lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // axi4-lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [qpc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // axi4-lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [qpc_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // encoder, synchronous to clk_i
   input wire logic phase_a_i,
   input wire logic phase_b_i,
   input wire logic index_i,
   // status outputs
   output logic [CW-1:0] position_count_o,
   output logic forward_o,
   output logic irq_o
);
   import qpc_pkg::*;

   // =============================================================
   // state
   typedef struct packed {
      logic aw_got;
      logic [ADDR_W-1:0] aw_addr;
      logic w_got;
      logic [DATA_W-1:0] w_data;
      logic [STRB_W-1:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
      logic enable;
      qpc_mode_t mode;
      logic init_mode;
      logic [CW-1:0] count;
      logic [CW-1:0] limit;
      logic [CW-1:0] init;
      logic first_seen;
      logic first_dir;
      logic pending;
      logic [1:0] ref_ab;
      logic [INT_W-1:0] int_stat;
      logic [INT_W-1:0] int_mask;
   } qpc_state_t;

   qpc_state_t r;
   qpc_state_t next_r;

   logic step;
   logic fwd;
   logic [1:0] ab;
   logic phase_err;
   logic dir_change;
   logic index_rise;
   logic wr_fire;
   logic [INT_W-1:0] events;
   logic [DATA_W-1:0] wval;
   logic [DATA_W-1:0] status_word;
   logic index_reset_mode;

   // =============================================================
   // helpers
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      case (a)
         OFF_CTRL, OFF_COUNT, OFF_LIMIT, OFF_INIT, OFF_STATUS,
         OFF_INT_STAT, OFF_INT_MASK: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   function automatic logic [DATA_W-1:0] merge_strb(
      input logic [DATA_W-1:0] old_v,
      input logic [DATA_W-1:0] new_v,
      input logic [STRB_W-1:0] strb);
      logic [DATA_W-1:0] res;
      res = old_v;
      for (int i = 0; i < STRB_W; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      merge_strb = res;
   endfunction

   // =============================================================
   // edge decoder; inputs are used as is, a resynchroniser is the
   // feeding logic's job and would only add latency here
   qpc_quad_decoder u_dec
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .phase_a_i(phase_a_i),
      .phase_b_i(phase_b_i),
      .index_i(index_i),
      .step_o(step),
      .forward_o(fwd),
      .ab_o(ab),
      .phase_err_o(phase_err),
      .dir_change_o(dir_change),
      .index_rise_o(index_rise)
   );

   // =============================================================
   // bus handshakes
   assign s_axi_awready = !r.aw_got && !r.bvalid;
   assign s_axi_wready = !r.w_got && !r.bvalid;
   assign s_axi_arready = !r.rvalid;
   assign wr_fire = r.aw_got && r.w_got && !r.bvalid;

   assign index_reset_mode = (r.mode == QPC_MODE_INDEX) && !r.init_mode;

   always_comb
   begin
      status_word = '0;
      status_word[ST_FIRST_SEEN] = r.first_seen;
      status_word[ST_FIRST_DIR] = r.first_dir;
      status_word[ST_DIR] = fwd;
      status_word[ST_PENDING] = r.pending;
      status_word[ST_REF_MSB:ST_REF_LSB] = r.ref_ab;
   end

   // =============================================================
   // next state
   always_comb
   begin
      next_r = r;
      events = '0;
      wval = '0;

      // write channel capture, either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_r.aw_got = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_r.w_got = 1'b1;
         next_r.w_data = s_axi_wdata;
         next_r.w_strb = s_axi_wstrb;
      end
      if (r.bvalid && s_axi_bready)
      begin
         next_r.bvalid = 1'b0;
      end

      // read channel
      if (r.rvalid && s_axi_rready)
      begin
         next_r.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_r.rvalid = 1'b1;
         next_r.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            OFF_CTRL: next_r.rdata = DATA_W'({r.init_mode, r.mode,
                                              r.enable});
            OFF_COUNT: next_r.rdata = DATA_W'(r.count);
            OFF_LIMIT: next_r.rdata = DATA_W'(r.limit);
            OFF_INIT: next_r.rdata = DATA_W'(r.init);
            OFF_STATUS: next_r.rdata = status_word;
            OFF_INT_STAT: next_r.rdata = DATA_W'(r.int_stat);
            OFF_INT_MASK: next_r.rdata = DATA_W'(r.int_mask);
            default: next_r.rdata = '0;
         endcase
      end

      // counting and index handling
      if (r.enable)
      begin
         events[INT_DIRCHG] = dir_change;
         events[INT_PHASE] = phase_err;
         if (step)
         begin
            if (fwd)
            begin
               if (r.mode != QPC_MODE_FREE && r.count == r.limit)
               begin
                  next_r.count = '0;
                  events[INT_WRAP] = 1'b1;
               end
               else
               begin
                  next_r.count = r.count + CW'(1);
               end
            end
            else
            begin
               if (r.mode != QPC_MODE_FREE && r.count == '0)
               begin
                  next_r.count = r.limit;
                  events[INT_WRAP] = 1'b1;
               end
               else
               begin
                  next_r.count = r.count - CW'(1);
               end
            end
         end

         // armed reset fires on the stored transition only; a reversal
         // under the index leaves it waiting, which may land it up to
         // four counts off until the next clean index
         if (r.pending && step && ab == r.ref_ab && index_reset_mode)
         begin
            next_r.pending = 1'b0;
            next_r.count = fwd ? '0 : r.limit;
         end

         if (index_rise)
         begin
            events[INT_INDEX] = 1'b1;
            if (!r.first_seen)
            begin
               next_r.first_seen = 1'b1;
               next_r.first_dir = fwd;
               next_r.ref_ab = ab;
               events[INT_FIRST] = 1'b1;
               if (!r.init_mode && (r.mode == QPC_MODE_INDEX ||
                                    r.mode == QPC_MODE_FIRST))
               begin
                  next_r.count = fwd ? '0 : r.limit;
               end
            end
            else if (index_reset_mode)
            begin
               // re-arming sets the wait again; a stale wait from a reversal is kept, not cleared
               next_r.pending = 1'b1;
            end
            if (r.init_mode)
            begin
               next_r.count = r.init;
               next_r.pending = 1'b0;
            end
         end
      end

      // register writes; software loads win over counting
      if (wr_fire)
      begin
         next_r.aw_got = 1'b0;
         next_r.w_got = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = is_mapped(r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         case (r.aw_addr)
            OFF_CTRL:
            begin
               wval = merge_strb(DATA_W'({r.init_mode, r.mode, r.enable}),
                                 r.w_data, r.w_strb);
               next_r.enable = wval[CTRL_EN_BIT];
               next_r.mode = qpc_mode_t'(wval[CTRL_MODE_MSB:CTRL_MODE_LSB]);
               next_r.init_mode = wval[CTRL_INIT_BIT];
               next_r.pending = 1'b0;
            end
            OFF_COUNT:
            begin
               wval = merge_strb(DATA_W'(r.count), r.w_data, r.w_strb);
               next_r.count = CW'(wval);
            end
            OFF_LIMIT:
            begin
               wval = merge_strb(DATA_W'(r.limit), r.w_data, r.w_strb);
               next_r.limit = CW'(wval);
            end
            OFF_INIT:
            begin
               wval = merge_strb(DATA_W'(r.init), r.w_data, r.w_strb);
               next_r.init = CW'(wval);
            end
            OFF_STATUS:
            begin
               // one clears the first-index record, a new marker wins
               wval = merge_strb('0, r.w_data, r.w_strb);
               if (wval[ST_FIRST_SEEN] && !events[INT_FIRST])
               begin
                  next_r.first_seen = 1'b0;
                  next_r.first_dir = 1'b0;
                  next_r.pending = 1'b0;
               end
            end
            OFF_INT_STAT:
            begin
               wval = merge_strb('0, r.w_data, r.w_strb);
               next_r.int_stat = r.int_stat & ~wval[INT_W-1:0];
            end
            OFF_INT_MASK:
            begin
               wval = merge_strb(DATA_W'(r.int_mask), r.w_data, r.w_strb);
               next_r.int_mask = wval[INT_W-1:0];
            end
            default:
            begin
               wval = '0;
            end
         endcase
      end

      // sticky events; a set in the clearing cycle survives
      next_r.int_stat = next_r.int_stat | events;
   end

   // =============================================================
   // registers
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         r <= '0;
         r.mode <= QPC_MODE_INDEX;
         r.limit <= CW'(LIMIT_RST);
         r.init <= CW'(INIT_RST);
      end
      else
      begin
         r <= next_r;
      end
   end

   // =============================================================
   // outputs
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign position_count_o = r.count;
   assign forward_o = fwd;
   assign irq_o = |(r.int_stat & r.int_mask);

   // prot bits carry no meaning for this slave
   logic unused_prot;
   assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule
